// ==== core/atk_readout.sv ====
// converter and touch key register block with interrupt
//
// Behaviour
// [RL1] converter result split: high byte, upper nibble
// [RL2] touch count split: lower nibble, low byte
// [RL3] touch logic off while power down set
// [RL4] touch done flag, zero while converting, resets one
// [RL5] two-bit touch clock rate, 00 slowest
// [RL6] charge transfer ignores rate and doubling
// [RL7] doubling bit reports doubled count
// [RL8] self-cap reference capacitor select, resets 100
// [RL9] charge transfer reads field as conversion time
// [RL10] converter channel, ground and bandgap codes
// [RL11] touch channel picks one of sixteen pads
// [RL12] port 0 pins 7..4 analog enables
// [RL13] shared interrupt needs own and global enable
// [RL14] port 3 mode 11 makes pin analog
// [RL15] clear done on start, latch then set
// [RL16] software reads result after done flag
`timescale 1ns/1ns
module atk_readout import atk_pkg::*; #(
  parameter logic [15:0] WIN_BASE = TOUCH_WIN_BASE
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [7:0]  bus_rdata,
  input  wire logic        global_irq_en,
  output logic             irq,
  input  wire logic [15:0] touch_pad,
  input  wire logic        adc_done_in,
  input  wire logic [11:0] adc_data_in,
  output logic             adc_start,
  output logic      [3:0]  adc_chan,
  output logic             adc_gnd_sel,
  output logic             adc_bandgap_sel,
  output logic             touch_enable,
  output logic      [3:0]  touch_chan,
  output logic      [2:0]  touch_ref_cap,
  output logic      [1:0]  touch_clk_rate,
  output logic             touch_charge_mode,
  output logic      [3:0]  port0_analog_en,
  output logic      [3:0]  port3_analog_en
);

  // whole block state in one word
  typedef struct packed {
    logic           tk_pd;     // touch_power_down
    logic           tk_eoc;    // touch_conversion_done
    logic [1:0]     tk_rate;   // touch_clock_rate_sel
    logic           tk_dbl;    // touch_counter_double
    logic [2:0]     tk_ref;    // touch_reference_cap_sel
    logic [3:0]     adc_ch;    // converter_channel_sel
    logic [3:0]     tk_ch;     // touch_channel_sel
    logic [3:0]     p0_aen;    // port0_analog_enable
    logic [7:0]     p3_mode;   // port 3 pins 3..0 modes
    logic           tk_charge; // charge_transfer_touch_mode
    logic           irq_en;    // convert_touch_irq_enable
    logic [1:0]     irq_stat;  // sticky events
    logic [1:0]     irq_mask;  // event mask
    atk_adc_state_t adc_state; // converter sequencer
    logic           adc_start; // start pulse to converter
    logic           done_prev; // last synced done level
    logic           adc_eoc;   // converter finished flag
    logic [11:0]    adc_res;   // latched converter result
    logic [7:0]     rdata;     // read data, one cycle late
  } atk_state_t;

  atk_state_t s_ff;  // registered state
  atk_state_t nxt_s; // next state

  logic [28:0] pins_s;     // synchronised pin bundle
  logic [15:0] pad_s;      // synced touch pads
  logic        adc_done_s; // synced converter done
  logic [11:0] adc_data_s; // synced converter data
  logic        pad_sel;    // selected pad level
  logic        tk_start;   // accepted touch start
  logic        tk_abort;   // power down mid conversion
  logic        tk_busy;    // counter running
  logic        tk_done;    // counter finish pulse
  logic [11:0] tk_result;  // latched touch count
  logic        adc_fin;    // converter finish event
  logic [1:0]  irq_clr;    // write one to clear mask
  logic        wr_cmd;     // write to command register

  // every pin passes two flops before use
  atk_sync #(
    .W (29)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   ({adc_done_in, adc_data_in, touch_pad}),
    .dout  (pins_s)
  );

  assign pad_s      = pins_s[15:0];
  assign adc_data_s = pins_s[27:16];
  assign adc_done_s = pins_s[28];

  // [RL11] selected pad drives the counter
  // [RL3] no pad activity reaches it in power down
  assign pad_sel = pad_s[s_ff.tk_ch] & ~s_ff.tk_pd;

  assign wr_cmd = bus_wr && (bus_addr == ADDR_COMMAND);
  // [RL3] start accepted only with touch enabled
  // the finish cycle is already idle, so a start is also refused while done pulses
  assign tk_start = wr_cmd && bus_wdata[CMD_TOUCH_START_BIT] && !s_ff.tk_pd && !tk_busy && !tk_done;
  assign tk_abort = s_ff.tk_pd;

  atk_touch_cnt #(
    .WIN_BASE (WIN_BASE)
  ) u_touch (
    .clk         (clk),
    .rst_b       (rst_b),
    .start       (tk_start),
    .abort       (tk_abort),
    .pad_level   (pad_sel),
    .charge_mode (s_ff.tk_charge),
    .clock_rate  (s_ff.tk_rate),
    .double_en   (s_ff.tk_dbl),
    .ref_sel     (s_ff.tk_ref),
    .busy        (tk_busy),
    .done        (tk_done),
    .result      (tk_result)
  );

  // next state: bus writes, reads, sequencer, events
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.adc_start = 1'b0;
    nxt_s.rdata     = 8'h00;
    nxt_s.done_prev = adc_done_s;
    adc_fin         = 1'b0;
    irq_clr         = 2'h0;

    // register writes
    if (bus_wr) begin
      case (bus_addr)
        ADDR_TOUCH_CTRL: begin
          // [RL3] power down bit, done flag not writable
          nxt_s.tk_pd   = bus_wdata[TCTRL_PD_BIT];
          // [RL5] touch clock rate field
          nxt_s.tk_rate = bus_wdata[TCTRL_RATE_LSB +: 2];
          // [RL7] doubling select
          nxt_s.tk_dbl  = bus_wdata[TCTRL_DBL_BIT];
          // [RL8] [RL9] reference or time select
          nxt_s.tk_ref  = bus_wdata[TCTRL_REF_LSB +: 3];
        end
        ADDR_CHAN_SEL: begin
          // [RL10] [RL11] both channel fields
          nxt_s.adc_ch = bus_wdata[7:4];
          nxt_s.tk_ch  = bus_wdata[3:0];
        end
        ADDR_P0_AEN: begin
          // [RL12] only bits 7..4 exist
          nxt_s.p0_aen = bus_wdata[7:4];
        end
        ADDR_IRQ_STATUS: begin
          irq_clr = bus_wdata[1:0];
        end
        ADDR_IRQ_MASK: begin
          nxt_s.irq_mask = bus_wdata[1:0];
        end
        ADDR_COMMAND: begin
          // start bits are strobes, not stored
          nxt_s.tk_charge = bus_wdata[CMD_MODE_BIT];
          nxt_s.irq_en    = bus_wdata[CMD_IRQ_EN_BIT];
        end
        ADDR_P3_MODE: begin
          nxt_s.p3_mode = bus_wdata;
        end
        default: begin
          // unmapped writes are dropped
        end
      endcase
    end

    // register reads, answered next cycle
    if (bus_rd) begin
      case (bus_addr)
        ADDR_ADC_LOW_TOUCH_HIGH: begin
          // [RL1] [RL2] shared nibble register
          nxt_s.rdata = {s_ff.adc_res[3:0], tk_result[11:8]};
        end
        ADDR_ADC_HIGH: begin
          // [RL1] result bits 11..4
          nxt_s.rdata = s_ff.adc_res[11:4];
        end
        ADDR_TOUCH_LOW: begin
          // [RL2] count bits 7..0
          nxt_s.rdata = tk_result[7:0];
        end
        ADDR_TOUCH_CTRL: begin
          // [RL4] done flag shows in bit 6
          nxt_s.rdata = {s_ff.tk_pd, s_ff.tk_eoc, s_ff.tk_rate, s_ff.tk_dbl, s_ff.tk_ref};
        end
        ADDR_CHAN_SEL: begin
          nxt_s.rdata = {s_ff.adc_ch, s_ff.tk_ch};
        end
        ADDR_P0_AEN: begin
          // low nibble reads zero
          nxt_s.rdata = {s_ff.p0_aen, 4'h0};
        end
        ADDR_IRQ_STATUS: begin
          nxt_s.rdata = {6'h00, s_ff.irq_stat};
        end
        ADDR_IRQ_MASK: begin
          nxt_s.rdata = {6'h00, s_ff.irq_mask};
        end
        ADDR_COMMAND: begin
          // [RL16] converter done flag for polling
          nxt_s.rdata = {2'h0, tk_busy, s_ff.adc_eoc, s_ff.irq_en, s_ff.tk_charge, 2'h0};
        end
        ADDR_P3_MODE: begin
          nxt_s.rdata = s_ff.p3_mode;
        end
        default: begin
          nxt_s.rdata = 8'h00;
        end
      endcase
    end

    // [RL15] touch done flag: clear on start, set on finish
    if (tk_start) begin
      nxt_s.tk_eoc = 1'b0;
    end
    // finish and abort come only after a start, so they win
    if (tk_done || (tk_busy && tk_abort)) begin
      nxt_s.tk_eoc = 1'b1;
    end

    // converter sequencer
    case (s_ff.adc_state)
      ADC_IDLE: begin
        if (wr_cmd && bus_wdata[CMD_ADC_START_BIT]) begin
          nxt_s.adc_start = 1'b1;
          nxt_s.adc_eoc   = 1'b0;
          nxt_s.adc_state = ADC_WAIT;
        end
      end
      ADC_WAIT: begin
        // data settle before done rises, so both arrive synced
        if (adc_done_s && !s_ff.done_prev && !s_ff.adc_start) begin
          nxt_s.adc_res   = adc_data_s;
          nxt_s.adc_eoc   = 1'b1;
          nxt_s.adc_state = ADC_IDLE;
          adc_fin         = 1'b1;
        end
      end
      default: begin
        nxt_s.adc_state = ADC_IDLE;
      end
    endcase

    // sticky events: a set in the clear cycle wins
    nxt_s.irq_stat = (s_ff.irq_stat & ~irq_clr);
    nxt_s.irq_stat[IRQ_TOUCH_BIT] = nxt_s.irq_stat[IRQ_TOUCH_BIT] | tk_done;
    nxt_s.irq_stat[IRQ_ADC_BIT]   = nxt_s.irq_stat[IRQ_ADC_BIT] | adc_fin;
  end

  // register the block state, reset values per field
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff           <= '{adc_state: ADC_IDLE, default: '0};
      // [RL3] touch starts powered down
      s_ff.tk_pd     <= RST_TOUCH_PD;
      // [RL4] done flag resets high
      s_ff.tk_eoc    <= RST_DONE_FLAG;
      s_ff.tk_rate   <= RST_TOUCH_RATE;
      s_ff.tk_dbl    <= RST_TOUCH_DBL;
      s_ff.tk_ref    <= RST_TOUCH_REF;
      s_ff.adc_ch    <= RST_ADC_CHAN;
      s_ff.tk_ch     <= RST_TOUCH_CHAN;
      s_ff.p0_aen    <= RST_P0_AEN;
      s_ff.p3_mode   <= RST_P3_MODE;
      s_ff.irq_mask  <= RST_IRQ_MASK;
      s_ff.adc_eoc   <= RST_DONE_FLAG;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // [RL13] interrupt gated by own and global enable
  assign irq = global_irq_en & s_ff.irq_en & (|(s_ff.irq_stat & s_ff.irq_mask));

  // [RL14] port 3 pins 3..0 analog when mode is 11
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_p3
      assign port3_analog_en[gi] = (s_ff.p3_mode[2*gi +: 2] == P3_MODE_ANALOG);
    end
  endgenerate

  // [RL10] channel routing and special codes
  assign adc_chan          = s_ff.adc_ch;
  assign adc_gnd_sel       = (s_ff.adc_ch == ADC_CHAN_GROUND);
  assign adc_bandgap_sel   = (s_ff.adc_ch == ADC_CHAN_BANDGAP);
  assign adc_start         = s_ff.adc_start;
  assign touch_enable      = ~s_ff.tk_pd;
  assign touch_chan        = s_ff.tk_ch;
  assign touch_ref_cap     = s_ff.tk_ref;
  assign touch_clk_rate    = s_ff.tk_rate;
  assign touch_charge_mode = s_ff.tk_charge;
  // [RL12] port 0 pins 7..4 analog enables
  assign port0_analog_en   = s_ff.p0_aen;
  assign bus_rdata         = s_ff.rdata;

endmodule

// ==== core/atk_pkg.sv ====
// shared constants and types of the converter and touch key readout
package atk_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_ADC_LOW_TOUCH_HIGH = 8'hAA; // adc_low_touch_high_data
  localparam logic [7:0] ADDR_ADC_HIGH           = 8'hAB; // adc_result_high_byte
  localparam logic [7:0] ADDR_TOUCH_LOW          = 8'hAC; // touch_counter_low_byte
  localparam logic [7:0] ADDR_TOUCH_CTRL         = 8'hAD; // touch_control
  localparam logic [7:0] ADDR_CHAN_SEL           = 8'hAE; // channel_select
  localparam logic [7:0] ADDR_P0_AEN             = 8'hAF; // port0_analog_enable
  localparam logic [7:0] ADDR_IRQ_STATUS         = 8'hB4; // sticky events, write one to clear
  localparam logic [7:0] ADDR_IRQ_MASK           = 8'hB5; // event mask
  localparam logic [7:0] ADDR_COMMAND            = 8'hB6; // start strobes, mode, irq enable
  localparam logic [7:0] ADDR_P3_MODE            = 8'hB7; // port 3 pins 3..0 mode fields

  // touch_control field positions
  localparam int TCTRL_PD_BIT   = 7;
  localparam int TCTRL_DONE_BIT = 6;
  localparam int TCTRL_RATE_LSB = 4;
  localparam int TCTRL_DBL_BIT  = 3;
  localparam int TCTRL_REF_LSB  = 0;

  // command register field positions
  localparam int CMD_ADC_START_BIT   = 0;
  localparam int CMD_TOUCH_START_BIT = 1;
  localparam int CMD_MODE_BIT        = 2;
  localparam int CMD_IRQ_EN_BIT      = 3;
  localparam int CMD_ADC_DONE_BIT    = 4;
  localparam int CMD_TOUCH_BUSY_BIT  = 5;

  // interrupt status and mask bit positions
  localparam int IRQ_TOUCH_BIT = 0;
  localparam int IRQ_ADC_BIT   = 1;

  // values after reset
  localparam logic       RST_TOUCH_PD   = 1'b1;
  localparam logic       RST_DONE_FLAG  = 1'b1;
  localparam logic [1:0] RST_TOUCH_RATE = 2'h0;
  localparam logic       RST_TOUCH_DBL  = 1'b0;
  localparam logic [2:0] RST_TOUCH_REF  = 3'h4;
  localparam logic [3:0] RST_ADC_CHAN   = 4'hF;
  localparam logic [3:0] RST_TOUCH_CHAN = 4'hF;
  localparam logic [3:0] RST_P0_AEN     = 4'h0;
  localparam logic [7:0] RST_P3_MODE    = 8'h55;
  localparam logic [1:0] RST_IRQ_MASK   = 2'h0;

  // special converter channel codes and the analog port 3 mode
  localparam logic [3:0] ADC_CHAN_GROUND   = 4'hA;
  localparam logic [3:0] ADC_CHAN_BANDGAP  = 4'hB;
  localparam logic [1:0] P3_MODE_ANALOG    = 2'h3;

  // touch gate window base, in prescaled ticks, before the reference shift
  localparam logic [15:0] TOUCH_WIN_BASE = 16'h0010;
  localparam logic [11:0] TOUCH_CNT_MAX  = 12'hFFF;

  // converter sequencer states
  typedef enum logic [0:0] {
    ADC_IDLE = 1'b0,
    ADC_WAIT = 1'b1
  } atk_adc_state_t;

  // touch counter states
  typedef enum logic [1:0] {
    TK_IDLE  = 2'b00,
    TK_RUN   = 2'b01,
    TK_LATCH = 2'b10
  } atk_tk_state_t;

endpackage

// ==== core/atk_sync.sv ====
// two flip-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module atk_sync import atk_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // first stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] s1_ff; // metastable catch stage
    logic [W-1:0] s2_ff; // settled stage
  } atk_sync_t;

  atk_sync_t s_ff;  // registered state
  atk_sync_t nxt_s; // next state

  // shift the pins one stage per clock
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.s1_ff = din;
    nxt_s.s2_ff = s_ff.s1_ff;
  end

  // synchronous active low reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.s2_ff;

endmodule

// ==== core/atk_touch_cnt.sv ====
// touch key gate window and pad edge counter
`timescale 1ns/1ns
module atk_touch_cnt import atk_pkg::*; #(
  parameter logic [15:0] WIN_BASE = TOUCH_WIN_BASE
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       pad_level,
  input  wire logic       charge_mode,
  input  wire logic [1:0] clock_rate,
  input  wire logic       double_en,
  input  wire logic [2:0] ref_sel,
  output logic            busy,
  output logic            done,
  output logic     [11:0] result
);

  // whole counter state in one word
  typedef struct packed {
    atk_tk_state_t state;    // sequencer
    logic          pad_prev; // last pad level for edges
    logic [2:0]    presc;    // tick prescaler
    logic [22:0]   win;      // gate ticks left
    logic [11:0]   cnt;      // running count
    logic [11:0]   result;   // last finished count
    logic          done;     // one cycle finish pulse
  } atk_tc_t;

  atk_tc_t s_ff;
  atk_tc_t nxt_s;
  logic [2:0] reload; // prescaler reload value
  logic       tick;   // window advances
  logic       hit;    // pad event to count

  // next state of the counter
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.done     = 1'b0;
    nxt_s.pad_prev = pad_level;
    // [RL5] rate: 00 divides by eight, 11 by one
    reload = 3'(3'h7 >> clock_rate);
    // [RL6] charge transfer ignores rate and doubling
    tick = charge_mode | (s_ff.presc == 3'h0);
    // [RL7] doubled data counts both pad edges
    hit = (double_en & ~charge_mode) ? (pad_level ^ s_ff.pad_prev) : (pad_level & ~s_ff.pad_prev);
    case (s_ff.state)
      TK_IDLE: begin
        if (start) begin
          nxt_s.cnt   = 12'h000;
          // [RL8] [RL9] bigger reference code, longer window
          nxt_s.win   = 23'(WIN_BASE) << ref_sel;
          nxt_s.presc = reload;
          nxt_s.state = TK_RUN;
        end
      end
      TK_RUN: begin
        if (abort) begin
          // power down drops the conversion, result kept
          nxt_s.state = TK_IDLE;
        end else begin
          // saturate instead of wrapping on a huge count
          if (hit && s_ff.cnt != TOUCH_CNT_MAX) begin
            nxt_s.cnt = s_ff.cnt + 12'h001;
          end
          if (tick) begin
            nxt_s.presc = reload;
            if (s_ff.win <= 23'h000001) begin
              nxt_s.state = TK_LATCH;
            end else begin
              nxt_s.win = s_ff.win - 23'h000001;
            end
          end else begin
            nxt_s.presc = s_ff.presc - 3'h1;
          end
        end
      end
      TK_LATCH: begin
        // [RL15] latch the count with the finish pulse
        nxt_s.result = s_ff.cnt;
        nxt_s.done   = 1'b1;
        nxt_s.state  = TK_IDLE;
      end
      default: begin
        nxt_s.state = TK_IDLE;
      end
    endcase
  end

  // register the counter state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= '{state: TK_IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign busy   = (s_ff.state != TK_IDLE);
  assign done   = s_ff.done;
  assign result = s_ff.result;

endmodule

// ==== tb/atk_readout_monitor.sv ====
// port checker of the converter and touch readout
`timescale 1ns/1ns
module atk_readout_monitor import atk_pkg::*; #(
  parameter logic [15:0] WIN_BASE = TOUCH_WIN_BASE
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic       global_irq_en,
  input wire logic       irq,
  input wire logic [3:0] adc_chan,
  input wire logic       adc_gnd_sel,
  input wire logic       adc_bandgap_sel,
  input wire logic       touch_enable,
  input wire logic [3:0] touch_chan,
  input wire logic [2:0] touch_ref_cap,
  input wire logic [1:0] touch_clk_rate,
  input wire logic [3:0] port0_analog_en,
  input wire logic [3:0] port3_analog_en
);
  // one clock domain, so one default clocking and reset
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_gnd_code: assert property (adc_gnd_sel == (adc_chan == ADC_CHAN_GROUND))
    else $error("ground select disagrees with channel");
  chk_bandgap_code: assert property (adc_bandgap_sel == (adc_chan == ADC_CHAN_BANDGAP))
    else $error("bandgap select disagrees with channel");
  chk_chan_write: assert property (bus_wr && bus_addr == ADDR_CHAN_SEL
    |=> {adc_chan, touch_chan} == $past(bus_wdata)) else $error("channel write lost");
  chk_chan_read: assert property (bus_rd && bus_addr == ADDR_CHAN_SEL
    |=> bus_rdata == $past({adc_chan, touch_chan})) else $error("channel read wrong");
  chk_p0_write: assert property (bus_wr && bus_addr == ADDR_P0_AEN
    |=> port0_analog_en == $past(bus_wdata[7:4])) else $error("port0 enables wrong");
  chk_p3_analog: assert property (bus_wr && bus_addr == ADDR_P3_MODE
    |=> port3_analog_en[0] == ($past(bus_wdata[1:0]) == P3_MODE_ANALOG)) else $error("port3 analog wrong");
  chk_ctrl_write: assert property (bus_wr && bus_addr == ADDR_TOUCH_CTRL |=>
    touch_enable != $past(bus_wdata[7]) && touch_clk_rate == $past(bus_wdata[5:4])
    && touch_ref_cap == $past(bus_wdata[2:0])) else $error("touch control fields wrong");
  chk_irq_global: assert property (!global_irq_en |-> !irq)
    else $error("interrupt without global enable");
  chk_reset_vals: assert property ($rose(rst_b) |-> !touch_enable && touch_ref_cap == 3'h4
    && touch_chan == 4'hF && adc_chan == 4'hF) else $error("reset values wrong");
endmodule

bind atk_readout atk_readout_monitor #(.WIN_BASE(WIN_BASE)) u_mon (.*);

// ==== tb/atk_pad_model.sv ====
// behavioural touch pads and converter front end
`timescale 1ns/1ns
module atk_pad_model (
  input  wire logic        clk,
  input  wire logic        adc_start,
  input  wire logic [3:0]  pad_sel,
  input  wire logic [11:0] adc_val,
  input  wire logic [7:0]  adc_wait,
  output logic      [15:0] touch_pad,
  output logic             adc_done_in,
  output logic      [11:0] adc_data_in
);
  int   cnt = -1;   // cycles since start, idle below zero
  int   w;          // signed copy avoids unsigned compares
  logic osc = 1'b0; // oscillator of the chosen pad
  assign w = int'(adc_wait);
  initial begin
    touch_pad = 16'h0000;
    adc_done_in = 1'b0;
    adc_data_in = 12'h000;
  end
  // one pad toggles each cycle, others rest low
  always @(posedge clk) begin
    osc <= ~osc;
    touch_pad <= 16'(osc) << pad_sel;
    cnt <= adc_start ? 0 : (cnt < 0 ? cnt : cnt + 1);
    // data settles three cycles before done rises
    if (cnt == w) adc_data_in <= adc_val;
    adc_done_in <= cnt >= w + 3 && cnt < w + 7;
    // a cycle after done falls the old data is gone
    if (cnt == w + 8) begin
      adc_data_in <= ~adc_val;
      cnt <= -1;
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench of the converter and touch readout
`timescale 1ns/1ns
module tb import atk_pkg::*;;
  localparam logic [15:0] WIN = 16'h0002; // short gate keeps runs brief
  logic        clk, rst_b, bus_wr, bus_rd, global_irq_en, irq, adc_start, adc_done_in;
  logic        adc_gnd_sel, adc_bandgap_sel, touch_enable, touch_charge_mode;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, adc_wait, v, r;
  logic [3:0]  adc_chan, touch_chan, port0_analog_en, port3_analog_en, pad_sel;
  logic [2:0]  touch_ref_cap;
  logic [1:0]  touch_clk_rate;
  logic [11:0] adc_data_in, adc_val;
  logic [15:0] touch_pad;
  logic [7:0]  mdl [logic [7:0]]; // expected writable registers
  int          miscompares = 0;
  int          samples_checked = 0;
  int          ex;
  // touch cases: control byte, charge mode, oscillating pad
  logic [7:0]  tc_ctl [8] = '{8'h32, 8'h3A, 8'h02, 8'h0A, 8'h03, 8'h23, 8'h32, 8'h10};
  bit          tc_chg [8] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  logic [3:0]  tc_pad [8] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3, 4'h5, 4'h3};

  atk_readout #(.WIN_BASE(WIN)) uut (.*);
  atk_pad_model pads (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // counts vary by a couple of edges with gate alignment
  task automatic cmp_rng(input logic [11:0] got, input int exp);
    samples_checked++;
    if ($isunknown(got) || int'(got) > exp + (exp ? 2 : 0) || int'(got) < exp - (exp ? 2 : 0)) begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clk);
    bus_wr <= 1'b0;
    // only writable bits move
    if (a == ADDR_TOUCH_CTRL) mdl[a] = {d[7], mdl[a][6], d[5:0]};
    else if (a == ADDR_P0_AEN) mdl[a] = {d[7:4], 4'h0};
    else if (a == ADDR_IRQ_MASK) mdl[a] = {6'h00, d[1:0]};
    else if (mdl.exists(a)) mdl[a] = d;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
    @(posedge clk);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    cmp8(d, e);
  endtask

  // poll a flag with a bounded number of reads
  task automatic wait_flag(input logic [7:0] a, input int b);
    logic [7:0] d;
    for (int k = 0; k < 300; k++) begin
      rd_reg(a, d);
      if (d[b] === 1'b1) break;
    end
    cmp8(d[b], 1'b1);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    final_report;
  end

  initial begin
    {rst_b, bus_wr, bus_rd, bus_addr, bus_wdata, global_irq_en} = 20'h0;
    {pad_sel, adc_val, adc_wait} = 24'h000004;
    mdl[ADDR_TOUCH_CTRL] = 8'hC4;
    mdl[ADDR_CHAN_SEL] = 8'hFF;
    mdl[ADDR_P0_AEN] = 8'h00;
    mdl[ADDR_IRQ_MASK] = 8'h00;
    mdl[ADDR_P3_MODE] = 8'h55;
    void'($urandom(32'hD6E2));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    foreach (mdl[k]) chk_reg(k, mdl[k]);
    chk_reg(ADDR_COMMAND, 8'h10);
    chk_reg(8'h00, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = {4'(i), 4'(15 - i)};
      wr_reg(ADDR_CHAN_SEL, v);
      cmp8({touch_chan, adc_chan}, {v[3:0], v[7:4]});
      cmp8({adc_gnd_sel, adc_bandgap_sel}, {i == 10, i == 11});
    end
    repeat (4) begin
      v = 8'($urandom());
      wr_reg(ADDR_P0_AEN, v);
      cmp8(port0_analog_en, v[7:4]);
      wr_reg(ADDR_P3_MODE, v);
      cmp8(port3_analog_en, {&v[7:6], &v[5:4], &v[3:2], &v[1:0]});
      wr_reg(ADDR_TOUCH_CTRL, v | 8'h80);
      foreach (mdl[k]) chk_reg(k, mdl[k]);
    end
    $display("test fields done");
    wr_reg(ADDR_COMMAND, 8'h08);
    global_irq_en <= 1'b1;
    for (int n = 0; n < 3; n++) begin
      adc_val <= 12'($urandom());
      adc_wait <= 8'(1 + n * 30);
      wr_reg(ADDR_IRQ_MASK, n == 2 ? 8'h00 : 8'h02);
      wr_reg(ADDR_COMMAND, 8'h09);
      wait_flag(ADDR_COMMAND, CMD_ADC_DONE_BIT);
      chk_reg(ADDR_ADC_HIGH, adc_val[11:4]);
      rd_reg(ADDR_ADC_LOW_TOUCH_HIGH, v);
      cmp8(v[7:4], adc_val[3:0]);
      chk_reg(ADDR_IRQ_STATUS, 8'h02);
      cmp8(irq, n != 2);
      global_irq_en <= 1'b0;
      @(posedge clk);
      cmp8(irq, 1'b0);
      global_irq_en <= 1'b1;
      wr_reg(ADDR_IRQ_STATUS, 8'h02);
      cmp8(irq, 1'b0);
    end
    wr_reg(ADDR_ADC_HIGH, ~adc_val[11:4]);
    chk_reg(ADDR_ADC_HIGH, adc_val[11:4]);
    $display("test converter done");
    wr_reg(ADDR_CHAN_SEL, 8'h03);
    for (int i = 0; i < 8; i++) begin
      pad_sel <= tc_pad[i];
      wr_reg(ADDR_TOUCH_CTRL, tc_ctl[i]);
      wr_reg(ADDR_COMMAND, {5'h00, tc_chg[i], 2'h0});
      cmp8(touch_charge_mode, tc_chg[i]);
      wr_reg(ADDR_COMMAND, {5'h00, tc_chg[i], 2'h2});
      rd_reg(ADDR_TOUCH_CTRL, v);
      cmp8(v[6], 1'b0);
      wait_flag(ADDR_TOUCH_CTRL, TCTRL_DONE_BIT);
      ex = (int'(WIN) << tc_ctl[i][2:0]) * (tc_chg[i] ? 1 : 8 >> tc_ctl[i][5:4]) / 2;
      if (tc_ctl[i][3] && !tc_chg[i]) ex = ex * 2;
      if (tc_pad[i] != 4'h3) ex = 0;
      rd_reg(ADDR_ADC_LOW_TOUCH_HIGH, v);
      rd_reg(ADDR_TOUCH_LOW, r);
      cmp_rng({v[3:0], r}, ex);
      chk_reg(ADDR_IRQ_STATUS, 8'h01);
      wr_reg(ADDR_IRQ_STATUS, 8'h01);
    end
    wr_reg(ADDR_TOUCH_CTRL, 8'h07);
    wr_reg(ADDR_COMMAND, 8'h02);
    wr_reg(ADDR_TOUCH_CTRL, 8'h87);
    chk_reg(ADDR_TOUCH_CTRL, 8'hC7);
    cmp8(touch_enable, 1'b0);
    wr_reg(ADDR_COMMAND, 8'h02);
    chk_reg(ADDR_COMMAND, 8'h10);
    chk_reg(ADDR_IRQ_STATUS, 8'h00);
    chk_reg(ADDR_TOUCH_LOW, r);
    $display("test touch done");
    final_report;
  end
endmodule
